// *** bench/halfflash_conv_model.sv ***
`timescale 1ns/10ps
module halfflash_conv_model
  import halfflash_host_pkg::*;
(
  input wire logic sys_clk,
  input wire adc_ctl_t adc_ctl,
  input wire logic [DATA_W-1:0] vin,
  input wire logic stall,
  output adc_stat_t adc_stat
);
  int cnt = 0;
  logic [DATA_W-1:0] res = 8'h00;
  // Undriven bus shows a moving pattern, not a held copy of the last byte
  logic [DATA_W-1:0] pat = 8'h00;
  logic done = 1'b0;
  logic wr_q = 1'b1;
  logic rd_q = 1'b0;
  logic sel_rd;
  assign sel_rd = !adc_ctl.cs_n && !adc_ctl.rd_n;
  always @(posedge sys_clk) begin
    pat <= pat + 8'h01;
    wr_q <= adc_ctl.wr_n;
    rd_q <= sel_rd;
    if (cnt > 0) cnt <= cnt - 1;
    if (cnt == 1 && !stall) done <= 1'b1;
    if (!sel_rd && rd_q) done <= 1'b0;
    if (!adc_ctl.mode && sel_rd && !rd_q) begin
      cnt <= 160;
      res <= vin;
    end
    if (adc_ctl.mode && !adc_ctl.wr_n && wr_q) done <= 1'b0;
    if (adc_ctl.mode && adc_ctl.wr_n && !wr_q) begin
      cnt <= 78;
      res <= vin;
    end
    if (adc_ctl.mode && sel_rd && !rd_q && cnt > 0) begin
      cnt <= 0;
      done <= 1'b1;
    end
  end
  // Open-drain ready already resolved: floats high
  assign adc_stat = '{
    int_n: !done,
    rdy: !(sel_rd && !adc_ctl.mode && !done),
    data: (sel_rd && done) ? res : pat
  };
endmodule : halfflash_conv_model

// *** bench/halfflash_host_tb_top.sv ***
`timescale 1ns/10ps
module halfflash_host_tb_top;
  import halfflash_host_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic start = 1'b0;
  op_mode_t op_mode = OP_RD;
  logic early_read = 1'b0;
  logic stall = 1'b0;
  logic [DATA_W-1:0] vin = 8'h00;
  logic busy;
  logic result_valid;
  logic timeout;
  logic [DATA_W-1:0] result;
  adc_ctl_t adc_ctl;
  adc_ctl_t ctl_q = 4'hF;
  adc_stat_t adc_stat;
  logic [DATA_W-1:0] exp_q[$];
  int n_errors = 0;
  int cmp_count = 0;
  int seed = 54;
  int wr_lo = 0;
  int since_wr = 1000;
  int since_done = 1000;
  always #5 sys_clk = ~sys_clk;

  halfflash_host DUT (.sys_clk(sys_clk), .reset_n(reset_n), .start(start), .op_mode(op_mode),
    .early_read(early_read), .busy(busy), .result(result), .result_valid(result_valid),
    .timeout(timeout), .adc_ctl(adc_ctl), .adc_stat(adc_stat));
  halfflash_conv_model model (.sys_clk(sys_clk), .adc_ctl(adc_ctl), .vin(vin), .stall(stall),
    .adc_stat(adc_stat));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic test_done();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done

  task automatic convert(input op_mode_t m, input logic er, input logic st);
    int n;
    op_mode = m;
    early_read = er;
    stall = st;
    vin = 8'($random(seed));
    if (!st) exp_q.push_back(vin);
    @(posedge sys_clk) #1;
    chk("mode pin", m != OP_RD, adc_ctl.mode);
    if (m == OP_STANDALONE) chk("idle select read", 2'b00, {adc_ctl.cs_n, adc_ctl.rd_n});
    // Random idle time before the start request
    repeat ($unsigned($random(seed)) % 8) @(posedge sys_clk) #1;
    start = 1'b1;
    @(posedge sys_clk) #1;
    start = 1'b0;
    for (n = 0; n < 1000 && busy !== 1'b0; n++) @(posedge sys_clk) #1;
    if (n == 1000) begin
      chk("busy wait", 0, 1);
      test_done();
    end
  endtask : convert

  // Pin watcher: results in order, plus pin timing between conversions
  always @(posedge sys_clk) begin
    #1;
    since_done++;
    since_wr++;
    if (result_valid === 1'b1) begin
      if (!stall && exp_q.size() == 0) chk("extra result", 0, 1);
      else if (!stall) chk("result", exp_q.pop_front(), result);
      since_done = 0;
    end
    if (adc_ctl.wr_n === 1'b0) wr_lo++;
    if (adc_ctl.wr_n && !ctl_q.wr_n) begin
      chk("write low cycles", WR_LOW_CYC, wr_lo);
      wr_lo = 0;
      since_wr = 0;
    end
    if ((!adc_ctl.wr_n && ctl_q.wr_n) || (!adc_ctl.mode && !adc_ctl.rd_n && ctl_q.rd_n))
      chk("zeroing gap", 1, since_done >= RECOVER_CYC);
    if (adc_ctl.mode && !adc_ctl.rd_n && ctl_q.rd_n)
      chk("read after write", 1, since_wr >= EARLY_RD_CYC);
    if (!adc_ctl.mode && !adc_ctl.rd_n && ctl_q.rd_n)
      chk("select at read", 0, adc_ctl.cs_n);
    ctl_q = adc_ctl;
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    for (int i = 0; i < 3; i++) begin
      convert(OP_RD, 1'b0, 1'b0);
      convert(OP_WR_RD, 1'b1, 1'b0);
      convert(OP_WR_RD, 1'b0, 1'b0);
      convert(OP_STANDALONE, 1'b0, 1'b0);
    end
    // Converter never signals done: host must give up and flag it
    convert(OP_WR_RD, 1'b0, 1'b1);
    chk("timeout flag", 1, timeout);
    convert(OP_WR_RD, 1'b1, 1'b0);
    chk("timeout flag", 0, timeout);
    chk("pending results", 0, exp_q.size());
    test_done();
  end
endmodule : halfflash_host_tb_top

// *** verilog/halfflash_host.sv ***
`timescale 1ns/10ps
// Summary of operation
// - Write starts; wait done line, 800 ns
// - Early read allowed 600 ns after write
// - Stand-alone: select, read held low
// - Write low pulse at most 50 us
// - Wait 500 ns zeroing before next start
// - Read-only start: read falls, select low
module halfflash_host
  import halfflash_host_pkg::*;
#(
  parameter int WR_MAX = WR_MAX_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic start,
  input wire op_mode_t op_mode,
  input wire logic early_read,
  output logic busy,
  output logic [DATA_W-1:0] result,
  output logic result_valid,
  output logic timeout,
  output adc_ctl_t adc_ctl,
  input wire adc_stat_t adc_stat
);

  ctl_state_t q;
  ctl_state_t d;
  adc_stat_t stat_s;
  logic standalone;

  // Ready, done and data cross in from the converter pins
  halfflash_pin_sync #(.W($bits(adc_stat_t))) u_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .din(adc_stat),
    .dout(stat_s)
  );

  assign standalone = (q.op == OP_STANDALONE);

  always_comb begin
    d = q;
    d.valid = 1'b0;
    d.cnt = q.cnt + CNT_W'(1);
    case (q.st)
      ST_IDLE: begin
        d.cnt = '0;
        d.op = op_mode;
        d.early = early_read;
        d.pins.mode = (op_mode != OP_RD);
        d.pins.cs_n = (op_mode != OP_STANDALONE);
        d.pins.rd_n = (op_mode != OP_STANDALONE);
        d.pins.wr_n = 1'b1;
        if (start) begin
          d.timeout = 1'b0;
          d.pins.cs_n = 1'b0;
          if (op_mode == OP_RD) begin
            d.pins.rd_n = 1'b0;
            d.st = ST_RD_LOW;
          end else begin
            d.pins.wr_n = 1'b0;
            d.st = ST_WR_LOW;
          end
        end
      end
      ST_WR_LOW: begin
        // Fixed width: long enough to settle, far below the droop limit
        if (q.cnt == CNT_W'(WR_LOW_CYC - 1)) begin
          d.pins.wr_n = 1'b1;
          d.cnt = '0;
          d.st = ST_WR_WAIT;
        end
      end
      ST_WR_WAIT: begin
        if (standalone) begin
          // Data pins settle, then pass the synchroniser
          if (q.cnt == CNT_W'(CONV_CYC + SYNC_STAGES)) begin
            d.result = stat_s.data;
            d.valid = 1'b1;
            d.cnt = '0;
            d.st = ST_RECOVER;
          end
        end else if (q.early) begin
          if (q.cnt == CNT_W'(EARLY_RD_CYC - 1)) begin
            d.pins.rd_n = 1'b0;
            d.cnt = '0;
            d.st = ST_RD_LOW;
          end
        end else if (!stat_s.int_n || q.cnt >= CNT_W'(TIMEOUT_CYC)) begin
          d.timeout = stat_s.int_n;
          d.pins.rd_n = 1'b0;
          d.cnt = '0;
          d.st = ST_RD_LOW;
        end
      end
      ST_RD_LOW: begin
        // Status is stale until the read edge has passed the synchroniser
        if ((q.op == OP_RD && q.cnt > CNT_W'(SYNC_STAGES)
             && !stat_s.int_n && stat_s.rdy)
            || (q.op != OP_RD && q.cnt == CNT_W'(RD_ACCESS_CYC + SYNC_STAGES))
            || q.cnt >= CNT_W'(TIMEOUT_CYC)) begin
          d.timeout = q.timeout || (q.cnt >= CNT_W'(TIMEOUT_CYC));
          d.result = stat_s.data;
          d.valid = 1'b1;
          d.pins.rd_n = 1'b1;
          d.pins.cs_n = 1'b1;
          d.cnt = '0;
          d.st = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        // Upper comparators re-zero before any new start
        if (q.cnt == CNT_W'(RECOVER_CYC - 1)) begin
          d.cnt = '0;
          d.st = ST_IDLE;
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q.st <= ST_IDLE;
      q.cnt <= '0;
      q.op <= OP_RD;
      q.early <= 1'b0;
      q.pins <= '{mode: 1'b0, cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1};
      q.result <= '0;
      q.valid <= 1'b0;
      q.timeout <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign busy = (q.st != ST_IDLE);
  assign result = q.result;
  assign result_valid = q.valid;
  assign timeout = q.timeout;
  assign adc_ctl = q.pins;

  // Helper counts for the checks below
  logic [15:0] wr_low_q;
  logic [15:0] gap_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_low_q <= '0;
      gap_q <= 16'hFFFF;
    end else begin
      wr_low_q <= q.pins.wr_n ? 16'h0000 : wr_low_q + 16'h0001;
      if (q.pins.wr_n && (q.pins.rd_n || standalone)) begin
        gap_q <= (gap_q == 16'hFFFF) ? gap_q : gap_q + 16'h0001;
      end else begin
        gap_q <= 16'h0000;
      end
    end
  end

  wr_max_width_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !q.pins.wr_n |-> wr_low_q < 16'(WR_MAX))
    else $error("write strobe held low too long");

  wr_min_width_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(q.pins.wr_n) |-> wr_low_q == 16'(WR_LOW_CYC))
    else $error("write strobe width wrong");

  start_gap_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($fell(q.pins.wr_n) || ($fell(q.pins.rd_n) && q.op == OP_RD))
      |-> gap_q >= 16'(RECOVER_CYC))
    else $error("conversion started before zeroing ended");

  early_read_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($fell(q.pins.rd_n) && q.op == OP_WR_RD) |-> gap_q >= 16'(EARLY_RD_CYC))
    else $error("read too soon after write");

  early_read_time_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($rose(q.pins.wr_n) && q.op == OP_WR_RD && q.early) |-> ##60 $fell(q.pins.rd_n))
    else $error("early read not taken on time");

  read_select_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !q.pins.rd_n |-> !q.pins.cs_n)
    else $error("read low without select");

  mode_stable_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (busy && $past(busy)) |-> $stable(q.pins.mode) && (q.pins.mode == (q.op != OP_RD)))
    else $error("mode pin moved during conversion");

  standalone_pins_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (busy && standalone) |-> !q.pins.cs_n && !q.pins.rd_n)
    else $error("standalone select or read released");

  done_wait_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($fell(q.pins.rd_n) && q.op == OP_WR_RD && !q.early)
      |-> !$past(stat_s.int_n) || q.timeout)
    else $error("read before done line fell");

  standalone_cap_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($rose(q.pins.wr_n) && standalone) |-> ##(CONV_CYC + SYNC_STAGES + 1) result_valid)
    else $error("standalone result not taken on time");

  valid_pulse_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    result_valid |=> !result_valid && q.st == ST_RECOVER)
    else $error("result valid longer than one cycle");

endmodule : halfflash_host

// *** verilog/halfflash_host_pkg.sv ***
package halfflash_host_pkg;

  localparam int CLK_NS = 10;
  localparam int SYNC_STAGES = 2;
  localparam int CNT_W = 12;
  localparam int DATA_W = 8;

  localparam int WR_LOW_NS = 600;
  localparam int WR_MAX_US = 50;
  localparam int CONV_NS = 800;
  localparam int EARLY_RD_NS = 600;
  localparam int RECOVER_NS = 500;
  localparam int SAMPLE_DLY_NS = 100;
  localparam int RD_ACCESS_NS = 200;
  localparam int TIMEOUT_NS = 4000;

  // Least times round up, the longest time rounds down
  localparam int WR_LOW_CYC = (WR_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_MAX_CYC = (WR_MAX_US * 1000) / CLK_NS;
  localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int EARLY_RD_CYC = (EARLY_RD_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
  localparam int SAMPLE_DLY_CYC = (SAMPLE_DLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_ACCESS_CYC = (RD_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int TIMEOUT_CYC = (TIMEOUT_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {OP_RD, OP_WR_RD, OP_STANDALONE} op_mode_t;

  typedef enum logic [2:0] {ST_IDLE, ST_WR_LOW, ST_WR_WAIT, ST_RD_LOW, ST_RECOVER} state_t;

  typedef struct packed {
    logic mode;
    logic cs_n;
    logic rd_n;
    logic wr_n;
  } adc_ctl_t;

  typedef struct packed {
    logic int_n;
    logic rdy;
    logic [DATA_W-1:0] data;
  } adc_stat_t;

  typedef struct packed {
    state_t st;
    logic [CNT_W-1:0] cnt;
    op_mode_t op;
    logic early;
    adc_ctl_t pins;
    logic [DATA_W-1:0] result;
    logic valid;
    logic timeout;
  } ctl_state_t;

endpackage : halfflash_host_pkg

// *** verilog/halfflash_pin_sync.sv ***
`timescale 1ns/10ps
module halfflash_pin_sync #(
  parameter int W = 10
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  // First stage feeds only the second stage
  always_comb begin
    s_d.meta = din;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.stable;

endmodule : halfflash_pin_sync
